// [common/cns_pkg.sv]
// Constants shared by the clock network selection block
package cns_pkg;
    // Network counts in one transceiver bank and its spine region
    localparam int NUM_GLB = 4;
    localparam int NUM_REG = 2;
    localparam int NUM_LPR = 2;
    localparam int NUM_SPR = 12;
    localparam int NUM_NET = NUM_GLB + NUM_REG + NUM_LPR + NUM_SPR;
    // First index of each network kind in the line vector
    localparam int NET_GLB = 0;
    localparam int NET_REG = NUM_GLB;
    localparam int NET_LPR = NUM_GLB + NUM_REG;
    localparam int NET_SPR = NUM_GLB + NUM_REG + NUM_LPR;
    localparam int NUM_GATED = NUM_GLB + NUM_REG;
    // Control unit source legs
    localparam int NUM_SRC = 8;
    localparam int SRC_SEL_W = 3;
    localparam int DYN_SEL_W = 2;
    localparam int SRC_XCVR = 4;
    localparam int SRC_IOPLL = 5;
    localparam int SRC_PHASE = 6;
    localparam int SRC_CORE = 7;
    // Legal legs: global/regional lack the phase aligner, periphery lacks core
    localparam logic [NUM_SRC-1:0] MASK_GR = 8'hbf;
    localparam logic [NUM_SRC-1:0] MASK_PERI = 8'h7f;
    // Fractional PLLs beside the bank and their counters
    localparam int NUM_FRACTIONAL_PLL = 2;
    localparam int NUM_FRACTIONAL_PLL_C = 4;
    localparam int NUM_PIN = 2;
    // Bits of a leg zero/one selector: counter pair member, then PLL
    localparam int IN_CNT_BIT = 0;
    localparam int IN_PLL_BIT = 1;
    // Section and row clock resources
    localparam int NUM_SEC = 33;
    localparam int SEC_SEL_W = 2;
    localparam int SEC_STRIDE = 5;
    localparam int NUM_ROW = 6;
    localparam int ROW_SEL_W = 6;
    // Layout of the synchronised source word
    localparam int SY_FRACTIONAL_PLL = 0;
    localparam int SY_IOPLL = SY_FRACTIONAL_PLL + NUM_FRACTIONAL_PLL * NUM_FRACTIONAL_PLL_C;
    localparam int SY_XCVR = SY_IOPLL + 1;
    localparam int SY_PHASE = SY_XCVR + 1;
    localparam int SY_REFP = SY_PHASE + 1;
    localparam int SY_REFN = SY_REFP + NUM_PIN;
    localparam int SY_IOP = SY_REFN + NUM_PIN;
    localparam int SY_ION = SY_IOP + 1;
    localparam int SYNC_W = SY_ION + 1;
    // Reset value of every state bit
    localparam logic STATE_RST = 1'h0;
endpackage

// [src/cns_clk_ctrl.sv]
// One network control unit: source select and optional gating
`timescale 1ns/1ns
module cns_clk_ctrl #(
    parameter bit HAS_DYN = 1'h0,
    parameter bit HAS_GATE = 1'h0,
    parameter logic [cns_pkg::NUM_SRC-1:0] SRC_MASK = cns_pkg::MASK_GR
) (
    input logic core_clk,
    input logic arst_n,
    input logic [cns_pkg::NUM_SRC-1:0] src,
    input logic [cns_pkg::SRC_SEL_W-1:0] cfg_sel,
    input logic cfg_dyn,
    input logic [cns_pkg::DYN_SEL_W-1:0] dyn_sel,
    input logic ena,
    output logic net_r
);
    import cns_pkg::*;

    // Enable metastability pair and the network output
    typedef struct packed {
        logic ena_meta;
        logic ena_s;
        logic net;
    } cns_ctrl_st_t;

    cns_ctrl_st_t st_r; // Registered state
    cns_ctrl_st_t st_nxt; // Next state
    logic [SRC_SEL_W-1:0] sel_used; // Leg in use
    logic picked; // Selected leg level

    // Select, gate and drive the network
    always_comb begin
        st_nxt = st_r;
        // Runtime select only where the unit allows it
        if (HAS_DYN && cfg_dyn) begin
            sel_used = {1'h0, dyn_sel};
        end else begin
            sel_used = cfg_sel;
        end
        // Legs that the network kind cannot reach stay low
        picked = src[sel_used] & SRC_MASK[sel_used];
        // Enable passes two flops; ungated units hold it high
        st_nxt.ena_meta = HAS_GATE ? ena : 1'h1;
        st_nxt.ena_s = st_r.ena_meta;
        st_nxt.net = picked & (st_r.ena_s | ~HAS_GATE);
    end

    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= {$bits(cns_ctrl_st_t){STATE_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign net_r = st_r.net;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    property p_gate_off;
        (HAS_GATE && !st_r.ena_s) |=> !net_r;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gated network drives");

    property p_static;
        (!HAS_DYN || !cfg_dyn) && (st_r.ena_s || !HAS_GATE)
            |=> net_r == $past(src[cfg_sel] & SRC_MASK[cfg_sel]);
    endproperty
    a_static: assert property (p_static) else $error("static leg not followed");

    property p_dyn;
        (HAS_DYN && cfg_dyn && st_r.ena_s)
            |=> net_r == $past(src[dyn_sel] & SRC_MASK[dyn_sel]);
    endproperty
    a_dyn: assert property (p_dyn) else $error("runtime leg not followed");

    property p_mask;
        !SRC_MASK[sel_used] |=> !net_r;
    endproperty
    a_mask: assert property (p_mask) else $error("illegal leg reached net");

    c_dyn_switch: cover property (HAS_DYN && cfg_dyn && $changed(dyn_sel));
    c_gate_off: cover property (HAS_GATE && $fell(st_r.ena_s));
endmodule // cns_clk_ctrl

// [src/cns_clock_net.sv]
// Clock network fabric: control units, section and row clocks
// How it works
// - Every network has its own control unit
// - Runtime source switching only on global networks
// - Gating only on global and regional networks
// - Leg zero takes counter C0 or C2
// - Leg one takes counter C1 or C3
// - Legs two, three take either bank pin
// - Section clocks choose lines by fixed pattern
// - At most 33 sections share all lines
// - Sections drive six row clocks per region
// - Twelve small periphery nets per bank
// - Two large periphery nets per bank
// - Phase aligner reaches periphery networks only
// - Core logic may drive global, regional nets
// - Transceiver clocks reach every network kind
// - PLL outputs reach every network kind
// - I/O PLL pins either mode, fractional differential
`timescale 1ns/1ns
module cns_clock_net (
    input logic core_clk,
    input logic arst_n,
    // Clock sources from outside the core domain
    input logic [cns_pkg::NUM_FRACTIONAL_PLL*cns_pkg::NUM_FRACTIONAL_PLL_C-1:0] frac_pll_cnt,
    input logic io_pll_clk,
    input logic xcvr_clk,
    input logic phase_aligner_clk,
    input logic [cns_pkg::NUM_PIN-1:0] refclk_p,
    input logic [cns_pkg::NUM_PIN-1:0] refclk_n,
    input logic io_clk_p,
    input logic io_clk_n,
    // Fabric logic on the core clock
    input logic [cns_pkg::NUM_GATED-1:0] core_drive,
    input logic [cns_pkg::NUM_GATED-1:0] net_ena,
    input logic [cns_pkg::NUM_GLB*cns_pkg::DYN_SEL_W-1:0] glb_dyn_sel,
    // Static configuration, captured once after reset
    input logic [cns_pkg::NUM_NET*cns_pkg::SRC_SEL_W-1:0] cfg_net_sel,
    input logic [cns_pkg::NUM_GLB-1:0] cfg_glb_dyn,
    input logic [1:0] cfg_in0_sel,
    input logic [1:0] cfg_in1_sel,
    input logic cfg_in2_pin,
    input logic cfg_in3_pin,
    input logic cfg_io_single,
    input logic [cns_pkg::NUM_SEC*cns_pkg::SEC_SEL_W-1:0] cfg_sec_sel,
    input logic [cns_pkg::NUM_ROW*cns_pkg::ROW_SEL_W-1:0] cfg_row_sel,
    // Network, row and reference outputs
    output logic [cns_pkg::NUM_GLB-1:0] global_clock_net_r,
    output logic [cns_pkg::NUM_REG-1:0] regional_net_r,
    output logic [cns_pkg::NUM_LPR-1:0] large_periphery_net_r,
    output logic [cns_pkg::NUM_SPR-1:0] small_periphery_net_r,
    output logic [cns_pkg::NUM_ROW-1:0] row_clk_r,
    output logic [cns_pkg::NUM_PIN-1:0] frac_pll_ref_r,
    output logic io_pll_ref_r
);
    import cns_pkg::*;

    // All state of the fabric
    typedef struct packed {
        // Two-stage source synchroniser
        logic [SYNC_W-1:0] sy1;
        logic [SYNC_W-1:0] sy2;
        // Static configuration, captured once after release
        logic cfg_done;
        logic [NUM_NET*SRC_SEL_W-1:0] c_net;
        logic [NUM_GLB-1:0] c_dyn;
        logic [1:0] c_in0;
        logic [1:0] c_in1;
        logic c_in2;
        logic c_in3;
        logic c_io_se;
        logic [NUM_SEC*SEC_SEL_W-1:0] c_sec;
        logic [NUM_ROW*ROW_SEL_W-1:0] c_row;
        // Section, row and reference stages
        logic [NUM_SEC-1:0] sec;
        logic [NUM_ROW-1:0] row;
        logic [NUM_PIN-1:0] fref;
        logic iref;
    } cns_fab_st_t;

    cns_fab_st_t st_r; // Registered state
    cns_fab_st_t st_nxt; // Next state
    logic [NUM_FRACTIONAL_PLL*NUM_FRACTIONAL_PLL_C-1:0] fractional_pll; // Synced PLL counters
    logic [NUM_PIN-1:0] ref_diff; // Differential bank pins
    logic [3:0] inclk; // Control unit legs zero to three
    logic [NUM_NET-1:0] nets; // All network lines
    logic [NUM_SEC-1:0] sec_src; // Section mux outputs
    logic [NUM_ROW-1:0] row_src; // Row mux outputs

    // Leg zero to three mapping from synced sources
    always_comb begin
        fractional_pll = st_r.sy2[SY_FRACTIONAL_PLL +: NUM_FRACTIONAL_PLL*NUM_FRACTIONAL_PLL_C];
        // Pins of a pair: high side minus low side
        ref_diff = st_r.sy2[SY_REFP +: NUM_PIN] & ~st_r.sy2[SY_REFN +: NUM_PIN];
        // Even counters of the chosen PLL
        inclk[0] = fractional_pll[{st_r.c_in0[IN_PLL_BIT], st_r.c_in0[IN_CNT_BIT], 1'h0}];
        // Odd counters of the chosen PLL
        inclk[1] = fractional_pll[{st_r.c_in1[IN_PLL_BIT], st_r.c_in1[IN_CNT_BIT], 1'h1}];
        // Either dedicated pin of the bank
        inclk[2] = ref_diff[st_r.c_in2];
        inclk[3] = ref_diff[st_r.c_in3];
    end

    // Global and regional control units
    // Loop index shared by both unit groups
    genvar gi;
    generate
        for (gi = 0; gi < NUM_GATED; gi = gi + 1) begin : g_gr
            logic [NUM_SRC-1:0] src_gr; // Legs of this unit
            logic [DYN_SEL_W-1:0] dsel; // Runtime select
            // Core drive, PLL and transceiver legs
            assign src_gr = {core_drive[gi], 1'h0, st_r.sy2[SY_IOPLL],
                             st_r.sy2[SY_XCVR], inclk};
            assign dsel = (gi < NUM_GLB) ? glb_dyn_sel[(gi%NUM_GLB)*DYN_SEL_W +: DYN_SEL_W]
                                         : {DYN_SEL_W{STATE_RST}};
            // One unit per network, switching only if global
            cns_clk_ctrl #(
                .HAS_DYN(gi < NUM_GLB),
                .HAS_GATE(1'h1),
                .SRC_MASK(MASK_GR)
            ) u_ctrl (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .src(src_gr),
                .cfg_sel(st_r.c_net[gi*SRC_SEL_W +: SRC_SEL_W]),
                .cfg_dyn((gi < NUM_GLB) ? st_r.c_dyn[gi%NUM_GLB] : 1'h0),
                .dyn_sel(dsel),
                .ena(net_ena[gi]),
                .net_r(nets[gi])
            );
        end
        // Periphery control units, fixed select and never gated
        for (gi = NUM_GATED; gi < NUM_NET; gi = gi + 1) begin : g_peri
            logic [NUM_SRC-1:0] src_pr; // Legs of this unit
            // Phase aligner, PLL and transceiver legs
            assign src_pr = {1'h0, st_r.sy2[SY_PHASE], st_r.sy2[SY_IOPLL],
                             st_r.sy2[SY_XCVR], inclk};
            cns_clk_ctrl #(
                .HAS_DYN(1'h0),
                .HAS_GATE(1'h0),
                .SRC_MASK(MASK_PERI)
            ) u_ctrl (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .src(src_pr),
                .cfg_sel(st_r.c_net[gi*SRC_SEL_W +: SRC_SEL_W]),
                .cfg_dyn(1'h0),
                .dyn_sel({DYN_SEL_W{STATE_RST}}),
                .ena(1'h1),
                .net_r(nets[gi])
            );
        end
    endgenerate

    // Section muxes over the shared lines, then row muxes
    always_comb begin
        int idx; // Line reached by a section leg
        int rs; // Section chosen by a row
        idx = 0;
        rs = 0;
        // Leg k of section s reaches line (s + k*stride) mod lines
        for (int s = 0; s < NUM_SEC; s++) begin
            idx = (s + int'(st_r.c_sec[s*SEC_SEL_W +: SEC_SEL_W]) * SEC_STRIDE) % NUM_NET;
            sec_src[s] = nets[idx];
        end
        // Row picks a section; codes past the last section give low
        for (int r = 0; r < NUM_ROW; r++) begin
            rs = int'(st_r.c_row[r*ROW_SEL_W +: ROW_SEL_W]);
            if (rs < NUM_SEC) begin
                row_src[r] = st_r.sec[rs % NUM_SEC];
            end else begin
                row_src[r] = STATE_RST;
            end
        end
    end

    // Next state: synchronisers, configuration capture, clock stages
    always_comb begin
        st_nxt = st_r;
        // Two flops before any logic sees a source
        st_nxt.sy1 = {io_clk_n, io_clk_p, refclk_n, refclk_p, phase_aligner_clk,
                      xcvr_clk, io_pll_clk, frac_pll_cnt};
        // Second stage is the only reader of the first
        st_nxt.sy2 = st_r.sy1;
        // Configuration taken on the first edge after release only
        if (!st_r.cfg_done) begin
            st_nxt.cfg_done = 1'h1;
            st_nxt.c_net = cfg_net_sel;
            st_nxt.c_dyn = cfg_glb_dyn;
            st_nxt.c_in0 = cfg_in0_sel;
            st_nxt.c_in1 = cfg_in1_sel;
            st_nxt.c_in2 = cfg_in2_pin;
            st_nxt.c_in3 = cfg_in3_pin;
            st_nxt.c_io_se = cfg_io_single;
            st_nxt.c_sec = cfg_sec_sel;
            st_nxt.c_row = cfg_row_sel;
        end
        // All 33 sections draw on the same line set
        st_nxt.sec = sec_src;
        // Six rows are the only way into the region
        st_nxt.row = row_src;
        // Fractional PLL reference: differential only
        st_nxt.fref = ref_diff;
        // I/O PLL reference: single-ended uses the high pin
        if (st_r.c_io_se) begin
            st_nxt.iref = st_r.sy2[SY_IOP];
        end else begin
            st_nxt.iref = st_r.sy2[SY_IOP] & ~st_r.sy2[SY_ION];
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= {$bits(cns_fab_st_t){STATE_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs; periphery nets span the bank's and adjacent region
    assign global_clock_net_r = nets[NET_GLB +: NUM_GLB];
    assign regional_net_r = nets[NET_REG +: NUM_REG];
    assign large_periphery_net_r = nets[NET_LPR +: NUM_LPR];
    assign small_periphery_net_r = nets[NET_SPR +: NUM_SPR];
    assign row_clk_r = st_r.row;
    assign frac_pll_ref_r = st_r.fref;
    assign io_pll_ref_r = st_r.iref;

    // Checks, all on the core clock, quiet during reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // Captured selects never move afterwards
    property p_cfg_hold;
        st_r.cfg_done |=> $stable(st_r.c_net) && $stable(st_r.c_sec) && $stable(st_r.c_row);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("static select moved");

    // Leg zero reaches only the even counters
    property p_in0;
        inclk[0] == (st_r.c_in0[IN_CNT_BIT] ? fractional_pll[{st_r.c_in0[IN_PLL_BIT], 2'h2}]
                                              : fractional_pll[{st_r.c_in0[IN_PLL_BIT], 2'h0}]);
    endproperty
    a_in0: assert property (p_in0) else $error("leg zero not C0 or C2");

    // Leg one reaches only the odd counters
    property p_in1;
        inclk[1] == (st_r.c_in1[IN_CNT_BIT] ? fractional_pll[{st_r.c_in1[IN_PLL_BIT], 2'h3}]
                                              : fractional_pll[{st_r.c_in1[IN_PLL_BIT], 2'h1}]);
    endproperty
    a_in1: assert property (p_in1) else $error("leg one not C1 or C3");

    // Section zero follows its patterned line
    property p_sec0;
        st_r.cfg_done |=> st_r.sec[0] ==
            $past(nets[int'(st_r.c_sec[SEC_SEL_W-1:0]) * SEC_STRIDE]);
    endproperty
    a_sec0: assert property (p_sec0) else $error("section zero off pattern");

    // Row zero stays low on an absent section
    property p_row0;
        (st_r.cfg_done && st_r.c_row[ROW_SEL_W-1:0] >= NUM_SEC) |=> !row_clk_r[0];
    endproperty
    a_row0: assert property (p_row0) else $error("row driven by absent section");

    // Pin pair to reference: two sync stages and one output stage
    property p_fref;
        $past(arst_n, 3) |-> frac_pll_ref_r == $past(refclk_p & ~refclk_n, 3);
    endproperty
    a_fref: assert property (p_fref) else $error("fractional reference not differential");

    // Single-ended reference follows the high pin alone
    property p_iref_se;
        ($past(arst_n, 3) && st_r.c_io_se)
            |-> io_pll_ref_r == $past(io_clk_p, 3);
    endproperty
    a_iref_se: assert property (p_iref_se) else $error("single-ended reference wrong");

    // Differential reference needs the pair to differ
    property p_iref_diff;
        ($past(arst_n, 3) && !st_r.c_io_se)
            |-> io_pll_ref_r == $past(io_clk_p & ~io_clk_n, 3);
    endproperty
    a_iref_diff: assert property (p_iref_diff) else $error("differential reference wrong");

    // Row zero follows its chosen section one edge later
    property p_row0_live;
        (st_r.cfg_done && st_r.c_row[ROW_SEL_W-1:0] < NUM_SEC)
            |=> row_clk_r[0] == $past(st_r.sec[st_r.c_row[ROW_SEL_W-1:0]]);
    endproperty
    a_row0_live: assert property (p_row0_live) else $error("row zero off its section");

    // Static selects are those present at the first edge after release
    property p_cfg_take;
        $rose(st_r.cfg_done)
            |-> st_r.c_net == $past(cfg_net_sel) && st_r.c_row == $past(cfg_row_sel);
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("static select not captured");

    // Main scenarios worth seeing
    c_row_toggle: cover property ($rose(row_clk_r[0]) ##1 $fell(row_clk_r[0]));
    c_glb_live: cover property (st_r.cfg_done && $rose(global_clock_net_r[0]));
    c_io_single: cover property (st_r.c_io_se && $rose(io_pll_ref_r));
endmodule // cns_clock_net

// [bench/cns_fabric_model.sv]
// Fabric-side partner: drives core levels, enables and runtime selects
`timescale 1ns/1ns
module cns_fabric_model (
    input logic core_clk,
    input logic arst_n,
    input logic [cns_pkg::NUM_GATED-1:0] want_drive,
    input logic [cns_pkg::NUM_GATED-1:0] want_ena,
    input logic [cns_pkg::NUM_GLB*cns_pkg::DYN_SEL_W-1:0] want_sel,
    input logic [cns_pkg::NUM_ROW-1:0] row_clk,
    output logic [cns_pkg::NUM_GATED-1:0] core_drive,
    output logic [cns_pkg::NUM_GATED-1:0] net_ena,
    output logic [cns_pkg::NUM_GLB*cns_pkg::DYN_SEL_W-1:0] glb_dyn_sel,
    output logic [cns_pkg::NUM_ROW-1:0] row_seen
);
    import cns_pkg::*;
    // Requests move on the falling edge, clear of the sampling edge
    always @(negedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Quiet fabric, networks enabled
            core_drive <= '0;
            net_ena <= '1;
            glb_dyn_sel <= '0;
        end else begin
            core_drive <= want_drive;
            net_ena <= want_ena;
            glb_dyn_sel <= want_sel;
        end
    end
    // Row clocks as the fabric consumes them
    always @(negedge core_clk) begin
        row_seen <= row_clk;
    end
endmodule // cns_fabric_model

// [bench/tb_top.sv]
// Self-checking bench for the clock network selection block
`timescale 1ns/1ns
module tb_top;
    import cns_pkg::*;
    logic core_clk, arst_n;
    logic [7:0] frac_pll_cnt;
    logic io_pll_clk, xcvr_clk, phase_aligner_clk, io_clk_p, io_clk_n;
    logic [1:0] refclk_p, refclk_n, cfg_in0_sel, cfg_in1_sel, f_ref;
    logic [5:0] core_drive, net_ena, want_drive, want_ena, row_clk, row_seen;
    logic [7:0] glb_dyn_sel, want_sel;
    logic [59:0] cfg_net_sel;
    logic [3:0] cfg_glb_dyn, g_net;
    logic cfg_in2_pin, cfg_in3_pin, cfg_io_single, io_ref;
    logic [65:0] cfg_sec_sel;
    logic [35:0] cfg_row_sel;
    logic [1:0] r_net, l_net;
    logic [11:0] s_net;
    int fails, tests_run;
    // Block under test
    cns_clock_net i_cns_clock_net (.core_clk(core_clk), .arst_n(arst_n),
        .frac_pll_cnt(frac_pll_cnt), .io_pll_clk(io_pll_clk), .xcvr_clk(xcvr_clk),
        .phase_aligner_clk(phase_aligner_clk), .refclk_p(refclk_p), .refclk_n(refclk_n),
        .io_clk_p(io_clk_p), .io_clk_n(io_clk_n), .core_drive(core_drive), .net_ena(net_ena),
        .glb_dyn_sel(glb_dyn_sel), .cfg_net_sel(cfg_net_sel), .cfg_glb_dyn(cfg_glb_dyn),
        .cfg_in0_sel(cfg_in0_sel), .cfg_in1_sel(cfg_in1_sel), .cfg_in2_pin(cfg_in2_pin),
        .cfg_in3_pin(cfg_in3_pin), .cfg_io_single(cfg_io_single), .cfg_sec_sel(cfg_sec_sel),
        .cfg_row_sel(cfg_row_sel), .global_clock_net_r(g_net), .regional_net_r(r_net),
        .large_periphery_net_r(l_net), .small_periphery_net_r(s_net), .row_clk_r(row_clk),
        .frac_pll_ref_r(f_ref), .io_pll_ref_r(io_ref));
    // Fabric partner
    cns_fabric_model i_cns_fabric_model (.core_clk(core_clk), .arst_n(arst_n),
        .want_drive(want_drive), .want_ena(want_ena), .want_sel(want_sel), .row_clk(row_clk),
        .core_drive(core_drive), .net_ena(net_ena), .glb_dyn_sel(glb_dyn_sel),
        .row_seen(row_seen));
    // Clock at 25 MHz
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Same source leg for every network
    function automatic logic [59:0] all_sel(input logic [2:0] k);
        logic [59:0] v;
        for (int i = 0; i < 20; i++) v[i*3 +: 3] = k;
        return v;
    endfunction
    // Let sync, unit and row stages land
    task automatic settle();
        repeat (6) @(negedge core_clk);
    endtask
    // Reset for 6 cycles; config is captured on the first edge after release
    task automatic do_reset();
        @(negedge core_clk);
        arst_n <= 1'b0;
        repeat (6) @(negedge core_clk);
        chk({g_net, r_net, l_net, s_net, row_clk, f_ref, io_ref}, 32'h0000_0000);
        arst_n <= 1'b1;
    endtask
    // Counter legs, pin legs and reference pin modes for every leg config
    task automatic t_legs();
        logic [1:0] vv;
        int i0;
        for (int v = 0; v < 4; v++) begin
            vv = v[1:0];
            i0 = vv[1] * 4 + vv[0] * 2;
            cfg_net_sel <= 60'h000_0000_0000_0688;
            cfg_in0_sel <= vv;
            cfg_in1_sel <= vv;
            cfg_in2_pin <= vv[0];
            cfg_in3_pin <= vv[1];
            cfg_io_single <= vv[0];
            do_reset();
            for (int b = 0; b < 8; b++) begin
                frac_pll_cnt <= 8'h01 << b;
                settle();
                chk(g_net[0], b == i0);
                chk(g_net[1], b == i0 + 1);
            end
            frac_pll_cnt <= 8'h00;
            for (int p = 0; p < 2; p++) begin
                // References come from the pins only
                refclk_p <= 2'h1 << p;
                refclk_n <= 2'h0;
                io_clk_p <= 1'b1;
                io_clk_n <= 1'b0;
                settle();
                chk(g_net[2], p == vv[0]);
                chk(g_net[3], p == vv[1]);
                chk(f_ref, 2'h1 << p);
                chk(io_ref, 1'b1);
            end
            refclk_n <= 2'h3;
            io_clk_n <= 1'b1;
            settle();
            chk(f_ref, 2'h0);
            chk(g_net[3:2], 2'h0);
            chk(io_ref, vv[0]);
            refclk_p <= 2'h0;
            refclk_n <= 2'h0;
        end
    endtask
    // Every leg on every network kind, masked legs give zero
    task automatic t_kinds();
        logic gr, pe;
        for (int k = 0; k < 8; k++) begin
            cfg_net_sel <= all_sel(k[2:0]);
            do_reset();
            settle();
            gr = (k >= 4) && (k != 6);
            pe = (k >= 4) && (k != 7);
            chk(g_net, {4{gr}});
            chk(r_net, {2{gr}});
            chk(l_net, {2{pe}});
            chk(s_net, {12{pe}});
            chk(row_clk, 6'h00);
        end
    endtask
    // Runtime select on one global net only; late config ignored
    task automatic t_dyn();
        cfg_net_sel <= 60'h000_0000_0000_0018;
        cfg_glb_dyn <= 4'h1;
        cfg_in0_sel <= 2'h0;
        cfg_in1_sel <= 2'h0;
        cfg_in2_pin <= 1'b0;
        cfg_in3_pin <= 1'b1;
        frac_pll_cnt <= 8'h01;
        refclk_p <= 2'h2;
        do_reset();
        @(negedge core_clk);
        cfg_net_sel <= all_sel(3'h6);
        for (int d = 0; d < 4; d++) begin
            want_sel <= {4{d[1:0]}};
            settle();
            chk(g_net[0], (d == 0) || (d == 3));
            chk(g_net[1], 1'b1);
            chk(r_net[0], 1'b1);
        end
        cfg_glb_dyn <= 4'h0;
        frac_pll_cnt <= 8'h00;
        refclk_p <= 2'h0;
    endtask
    // Gating on global and regional nets, with its latency
    task automatic t_gate();
        cfg_net_sel <= all_sel(3'h4);
        do_reset();
        settle();
        chk({r_net, g_net}, 6'h3f);
        want_ena <= 6'h1e;
        repeat (3) @(negedge core_clk);
        chk(g_net[0], 1'b1);
        @(negedge core_clk);
        chk(g_net[0], 1'b0);
        settle();
        chk({r_net, g_net}, 6'h1e);
        chk({l_net, s_net}, 14'h3fff);
        want_ena <= 6'h3f;
    endtask
    // One live net at a time, seen through sections and rows
    task automatic t_rows();
        logic [59:0] sel;
        logic [65:0] sec;
        logic [5:0] exp;
        for (int s = 0; s < 33; s++) sec[s*2 +: 2] = s[1:0];
        for (int t = 0; t < 20; t++) begin
            sel = all_sel(3'h0);
            sel[t*3 +: 3] = 3'h4;
            cfg_net_sel <= sel;
            cfg_sec_sel <= sec;
            cfg_row_sel <= {6'h3f, 6'h21, 6'h13, 6'h20, 6'h07, 6'h00};
            do_reset();
            settle();
            exp = {2'h0, t == 14, t == 12, t == 2, t == 0};
            chk(row_clk, exp);
            chk(row_seen, exp);
        end
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    // Main sequence
    initial begin
        fails = 0;
        tests_run = 0;
        arst_n = 1'b0;
        {frac_pll_cnt, io_clk_p, io_clk_n} = '0;
        {refclk_p, refclk_n, cfg_in0_sel, cfg_in1_sel, cfg_glb_dyn} = '0;
        {cfg_in2_pin, cfg_in3_pin, cfg_io_single, cfg_net_sel} = '0;
        {cfg_sec_sel, want_sel} = '0;
        // Rows point past the last section until the row scenario
        cfg_row_sel = {6{6'h3f}};
        xcvr_clk = 1'b1;
        io_pll_clk = 1'b1;
        phase_aligner_clk = 1'b1;
        want_drive = 6'h3f;
        want_ena = 6'h3f;
        t_legs();
        t_kinds();
        t_dyn();
        t_gate();
        t_rows();
        end_sim();
    end
endmodule // tb_top
